// *** src/tmr_chan_pkg.sv ***
// Purpose: Constants and carriers for the timer channel capture and output-flag control.
// Assumes: One channel per instance, 16-bit register port, word addresses.
// Notes:   Offsets, fields and reset values are named here once.
package tmr_chan_pkg;

	// Register word addresses
	localparam logic [3:0] ADDR_CTRL       = 4'h0;
	localparam logic [3:0] ADDR_CAPTURE    = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'h3;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;

	// Control register field positions
	localparam int BIT_EDGE_FLAG   = 11;
	localparam int BIT_IN_INVERT   = 9;
	localparam int BIT_IN_LEVEL    = 8;
	localparam int BIT_CAPTURE_VALUE_REGISTER_HI     = 7;
	localparam int BIT_CAPTURE_VALUE_REGISTER_LO     = 6;
	localparam int BIT_BROADCAST   = 5;
	localparam int BIT_SIB_FORCE   = 4;
	localparam int BIT_FORCE_LEVEL = 3;
	localparam int BIT_FORCE       = 2;
	localparam int BIT_OUT_INVERT  = 1;
	localparam int BIT_DRIVE_EN    = 0;

	// Interrupt status bit positions
	localparam int IRQ_EDGE    = 0;
	localparam int IRQ_SIBLING = 1;
	localparam int IRQ_W       = 2;

	// Capture mode codes
	typedef enum logic [1:0] {
		CAPTURE_VALUE_REGISTER_OFF     = 2'h0,
		CAPTURE_VALUE_REGISTER_RISING  = 2'h1,
		CAPTURE_VALUE_REGISTER_FALLING = 2'h2,
		CAPTURE_VALUE_REGISTER_BOTH    = 2'h3
	} capture_value_register_mode_e;

	localparam logic [2:0] COUNT_MODE_STOP = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	// Software-held control fields
	typedef struct packed {
		logic       in_invert;
		capture_value_register_mode_e capture_value_register_mode;
		logic       broadcast_en;
		logic       sibling_force_en;
		logic       forced_level;
		logic       out_invert;
		logic       drive_en;
	} chan_ctrl_s;

	localparam chan_ctrl_s CTRL_RESET = '{1'b0, CAPTURE_VALUE_REGISTER_OFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

	// Register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

endpackage

// *** src/capture_edge_detect.sv ***
// Purpose: Edge qualification of the polarity-adjusted capture input.
// Assumes: Input is synchronous to the system clock.
// Notes:   Pulse output is combinational, one cycle per qualifying edge.
module capture_edge_detect
	import tmr_chan_pkg::*;
(
	// Clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_reset_n,
	// Input and mode
	input  wire logic                     i_level,
	input  wire tmr_chan_pkg::capture_value_register_mode_e i_mode,
	// Result
	output logic                          o_edge
);
	import tmr_chan_pkg::*;

	logic level_prev_ff;

	// Previous level for edge detection
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
			level_prev_ff <= 1'b0;
		else
			level_prev_ff <= i_level;
	end

	wire rise = i_level & ~level_prev_ff;
	wire fall = ~i_level & level_prev_ff;

	// Mode selects which edges qualify
	assign o_edge = (i_mode == CAPTURE_VALUE_REGISTER_RISING)  ? rise :
	                (i_mode == CAPTURE_VALUE_REGISTER_FALLING) ? fall :
	                (i_mode == CAPTURE_VALUE_REGISTER_BOTH)    ? (rise | fall) : 1'b0;

endmodule // capture_edge_detect

// *** src/tmr_chan_ctrl.sv ***
// Purpose: Capture mode, compare broadcast, sibling and software flag force, output polarity and pin drive.
// Assumes: Pin and sibling inputs synchronous to i_clk_sys; counter value supplied by the count logic.
// Notes:   Software force wins over sibling force, which wins over counter updates of the flag.
//
// The placing of the registers and strobed register access are this design's own decisions.
module tmr_chan_ctrl
	import tmr_chan_pkg::*;
#(
	parameter int CNT_W    = 16,
	parameter int N_SRC    = 4,
	parameter int SRC_W    = 2,
	parameter int OWN_PIN  = 0
)
(
	// Clock and reset
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_reset_n,
	// Register port
	input  wire tmr_chan_pkg::reg_req_s     i_reg,
	output logic [15:0]                     o_rdata,
	// Counter side
	input  wire logic [CNT_W-1:0]           i_count_value,
	input  wire logic [2:0]                 i_count_mode,
	input  wire logic                       i_compare,
	input  wire logic                       i_flag_update,
	input  wire logic                       i_flag_value,
	input  wire logic [SRC_W-1:0]           i_sec_src_sel,
	// Sibling channels
	input  wire logic                       i_sibling_cmp,
	output logic                            o_broadcast_cmp,
	// External pins
	input  wire logic [N_SRC-1:0]           i_pin_in,
	output logic                            o_pin_out,
	output logic                            o_pin_oe_n,
	// Status outputs
	output logic                            o_timer_output_signal,
	output logic                            o_input_edge_event,
	output logic [CNT_W-1:0]                o_capture_value,
	output logic                            o_irq
);
	import tmr_chan_pkg::*;

	chan_ctrl_s        ctrl_ff;
	chan_ctrl_s        nxt_ctrl;
	logic              edge_flag_ff;
	logic              flag_ff;
	logic              nxt_flag;
	logic [CNT_W-1:0]  capture_value_register_ff;
	logic [IRQ_W-1:0]  irq_stat_ff;
	logic [IRQ_W-1:0]  irq_en_ff;
	logic [15:0]       rdata_ff;
	logic [15:0]       nxt_rdata;
	logic              pin_out_ff;
	logic              pin_oe_n_ff;
	logic              bcast_ff;
	logic              irq_ff;
	logic              edge_q;

	// Register decode
	wire wr_ctrl  = i_reg.wr && (i_reg.addr == ADDR_CTRL);
	wire wr_clear = i_reg.wr && (i_reg.addr == ADDR_IRQ_CLEAR);
	wire wr_en    = i_reg.wr && (i_reg.addr == ADDR_IRQ_ENABLE);
	wire rd_any   = i_reg.rd;

	// Polarity-adjusted flag as it leaves the channel
	wire flag_out = flag_ff ^ ctrl_ff.out_invert;

	// Selected secondary input, own driven value seen when driving
	wire src_raw  = (int'(i_sec_src_sel) == OWN_PIN && ctrl_ff.drive_en)
	              ? flag_out : i_pin_in[i_sec_src_sel];
	wire src_adj  = src_raw ^ ctrl_ff.in_invert;

	capture_edge_detect u_edge (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_level   (src_adj),
		.i_mode    (ctrl_ff.capture_value_register_mode),
		.o_edge    (edge_q)
	);

	// Edge flag and flag force qualification
	wire edge_set  = edge_q && (i_count_mode != COUNT_MODE_STOP);
	wire edge_clr  = wr_ctrl && !i_reg.wdata[BIT_EDGE_FLAG];
	wire sib_force = i_sibling_cmp && ctrl_ff.sibling_force_en;
	wire sw_force  = wr_ctrl && i_reg.wdata[BIT_FORCE];

	// Control fields from a control write
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl)
		begin
			nxt_ctrl.in_invert        = i_reg.wdata[BIT_IN_INVERT];
			nxt_ctrl.capture_value_register_mode        = capture_value_register_mode_e'(i_reg.wdata[BIT_CAPTURE_VALUE_REGISTER_HI:BIT_CAPTURE_VALUE_REGISTER_LO]);
			nxt_ctrl.broadcast_en     = i_reg.wdata[BIT_BROADCAST];
			nxt_ctrl.sibling_force_en = i_reg.wdata[BIT_SIB_FORCE];
			nxt_ctrl.forced_level     = i_reg.wdata[BIT_FORCE_LEVEL];
			nxt_ctrl.out_invert       = i_reg.wdata[BIT_OUT_INVERT];
			nxt_ctrl.drive_en         = i_reg.wdata[BIT_DRIVE_EN];
		end
	end

	// Flag priority: software force, sibling force, counter update
	always_comb
	begin
		nxt_flag = flag_ff;
		if (sw_force)
			nxt_flag = i_reg.wdata[BIT_FORCE_LEVEL];
		else if (sib_force)
			nxt_flag = ctrl_ff.forced_level;
		else if (i_flag_update)
			nxt_flag = i_flag_value;
	end

	// Read mux, force bit always zero
	always_comb
	begin
		nxt_rdata = 16'h0000;
		if (rd_any)
		begin
			case (i_reg.addr)
				ADDR_CTRL:
				begin
					nxt_rdata[BIT_EDGE_FLAG]           = edge_flag_ff;
					nxt_rdata[BIT_IN_INVERT]           = ctrl_ff.in_invert;
					nxt_rdata[BIT_IN_LEVEL]            = src_adj;
					nxt_rdata[BIT_CAPTURE_VALUE_REGISTER_HI:BIT_CAPTURE_VALUE_REGISTER_LO] = ctrl_ff.capture_value_register_mode;
					nxt_rdata[BIT_BROADCAST]           = ctrl_ff.broadcast_en;
					nxt_rdata[BIT_SIB_FORCE]           = ctrl_ff.sibling_force_en;
					nxt_rdata[BIT_FORCE_LEVEL]         = ctrl_ff.forced_level;
					nxt_rdata[BIT_FORCE]               = 1'b0;
					nxt_rdata[BIT_OUT_INVERT]          = ctrl_ff.out_invert;
					nxt_rdata[BIT_DRIVE_EN]            = ctrl_ff.drive_en;
				end
				ADDR_CAPTURE:    nxt_rdata[CNT_W-1:0] = capture_value_register_ff;
				ADDR_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
				ADDR_IRQ_ENABLE: nxt_rdata[IRQ_W-1:0] = irq_en_ff;
				default:         nxt_rdata = 16'h0000;
			endcase
		end
	end

	// Interrupt events, set wins over clear
	wire [IRQ_W-1:0] irq_evt = {sib_force, edge_set};
	wire [IRQ_W-1:0] irq_clr = wr_clear ? i_reg.wdata[IRQ_W-1:0] : IRQ_RESET;
	wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

	// Control and flag state
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ctrl_ff      <= CTRL_RESET;
			flag_ff      <= 1'b0;
			edge_flag_ff <= 1'b0;
		end
		else
		begin
			ctrl_ff      <= nxt_ctrl;
			flag_ff      <= nxt_flag;
			edge_flag_ff <= edge_set | (edge_flag_ff & ~edge_clr);
		end
	end

	// Capture register
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
			capture_value_register_ff <= '0;
		else if (edge_q)
			capture_value_register_ff <= i_count_value;
	end

	// Interrupt registers
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			irq_stat_ff <= IRQ_RESET;
			irq_en_ff   <= IRQ_RESET;
			irq_ff      <= 1'b0;
		end
		else
		begin
			irq_stat_ff <= nxt_irq_stat;
			irq_en_ff   <= wr_en ? i_reg.wdata[IRQ_W-1:0] : irq_en_ff;
			irq_ff      <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// Pin, broadcast and read data outputs
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pin_out_ff  <= 1'b0;
			pin_oe_n_ff <= 1'b1;
			bcast_ff    <= 1'b0;
			rdata_ff    <= 16'h0000;
		end
		else
		begin
			pin_out_ff  <= nxt_flag ^ nxt_ctrl.out_invert;
			pin_oe_n_ff <= ~nxt_ctrl.drive_en;
			bcast_ff    <= i_compare & ctrl_ff.broadcast_en;
			rdata_ff    <= nxt_rdata;
		end
	end

	assign o_rdata               = rdata_ff;
	assign o_pin_out             = pin_out_ff;
	assign o_pin_oe_n            = pin_oe_n_ff;
	assign o_broadcast_cmp       = bcast_ff;
	assign o_timer_output_signal = flag_ff;
	assign o_input_edge_event    = edge_flag_ff;
	assign o_capture_value       = capture_value_register_ff;
	assign o_irq                 = irq_ff;

endmodule // tmr_chan_ctrl

// *** bench/tmr_chan_ctrl_props.sv ***
// Purpose: Port-level assertions for the channel control block.
// Assumes: Single clock domain, async active-low reset.
// Notes:   Bound to every tmr_chan_ctrl instance.
module tmr_chan_ctrl_props
	import tmr_chan_pkg::*;
#(parameter int CNT_W = 16)
(
	// Clock, reset and register port
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_reset_n,
	input  wire tmr_chan_pkg::reg_req_s i_reg,
	input  wire logic [15:0]            o_rdata,
	// Counter and sibling side
	input  wire logic [CNT_W-1:0]       i_count_value,
	input  wire logic [2:0]             i_count_mode,
	input  wire logic                   i_compare,
	input  wire logic                   i_flag_update,
	input  wire logic                   i_sibling_cmp,
	input  wire logic                   o_broadcast_cmp,
	// Pin and status
	input  wire logic                   o_pin_out,
	input  wire logic                   o_pin_oe_n,
	input  wire logic                   o_timer_output_signal,
	input  wire logic                   o_input_edge_event,
	input  wire logic [CNT_W-1:0]       o_capture_value
);
	timeunit 1ns;
	timeprecision 1ps;
	// Control register write decode
	wire logic wc = i_reg.wr && i_reg.addr == ADDR_CTRL;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	AST_FORCE: assert property (wc && i_reg.wdata[2] |=> o_timer_output_signal == $past(i_reg.wdata[3]))
		else $error("forced level not on flag");
	AST_RD_ZERO: assert property (i_reg.rd && i_reg.addr == ADDR_CTRL |=> !o_rdata[2])
		else $error("force bit read back set");
	AST_DRIVE: assert property (wc |=> o_pin_oe_n == !$past(i_reg.wdata[0]))
		else $error("pin direction wrong");
	AST_INVERT: assert property (wc |=> o_pin_out == (o_timer_output_signal ^ $past(i_reg.wdata[1])))
		else $error("pin polarity wrong");
	AST_BCAST: assert property (o_broadcast_cmp |-> $past(i_compare))
		else $error("broadcast without compare");
	AST_EDGE: assert property ($rose(o_input_edge_event) |-> $past(i_count_mode) != COUNT_MODE_STOP)
		else $error("edge flag set while stopped");
	AST_CAPTURE_VALUE_REGISTER: assert property ($changed(o_capture_value) |-> o_capture_value == $past(i_count_value))
		else $error("capture value not counter");
	AST_FLAG_CAUSE: assert property ($changed(o_timer_output_signal) |-> $past(i_sibling_cmp || i_flag_update || wc))
		else $error("flag changed without cause");

	// Main scenarios reached
	cover property (wc && i_reg.wdata[2]);
	cover property ($rose(o_input_edge_event));
	cover property (o_broadcast_cmp);
endmodule // tmr_chan_ctrl_props

bind tmr_chan_ctrl tmr_chan_ctrl_props #(.CNT_W(CNT_W)) props (
	.i_clk_sys             (i_clk_sys),
	.i_reset_n             (i_reset_n),
	.i_reg                 (i_reg),
	.o_rdata               (o_rdata),
	.i_count_value         (i_count_value),
	.i_count_mode          (i_count_mode),
	.i_compare             (i_compare),
	.i_flag_update         (i_flag_update),
	.i_sibling_cmp         (i_sibling_cmp),
	.o_broadcast_cmp       (o_broadcast_cmp),
	.o_pin_out             (o_pin_out),
	.o_pin_oe_n            (o_pin_oe_n),
	.o_timer_output_signal (o_timer_output_signal),
	.o_input_edge_event    (o_input_edge_event),
	.o_capture_value       (o_capture_value)
);

// *** bench/pin_world.sv ***
// Purpose: Far side model: external pins and sibling channels.
// Assumes: Levels and sibling pulses are commanded by the bench.
// Notes:   Pin 0 carries the channel's own drive when enabled.
module pin_world
(
	// Commands from bench
	input  wire logic       i_clk_sys,
	input  wire logic [3:0] i_level,
	input  wire logic       i_sib_req,
	// Channel drive
	input  wire logic       i_pin_out,
	input  wire logic       i_pin_oe_n,
	// Toward channel
	output logic [3:0]      o_pins,
	output logic            o_sib
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shared pin shows the driven value
	assign o_pins = {i_level[3:1], i_pin_oe_n ? i_level[0] : i_pin_out};
	// Sibling compare pulse, one cycle
	always_ff @(posedge i_clk_sys)
		o_sib <= i_sib_req;
endmodule // pin_world

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the channel control block.
// Assumes: Secondary source is pin 2, own pin is 0.
// Notes:   Watchdog bounds the run.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_chan_pkg::*;
	logic clk = 0, rst_n = 0, cmp = 0, fupd = 0, fval = 0, sib_req = 0;
	logic sib, bcast, pout, poe_n, tflag, eflag, irq;
	logic [2:0] cmode = 0;
	logic [1:0] sel = 2'h2;
	logic [3:0] lvl = 0, pins;
	logic [15:0] cv = 0, rdata, capv;
	reg_req_s req = '0;
	int checks = 0, bad_count = 0;

	tmr_chan_ctrl dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg(req), .o_rdata(rdata), .i_count_value(cv),
		.i_count_mode(cmode), .i_compare(cmp), .i_flag_update(fupd), .i_flag_value(fval), .i_sec_src_sel(sel),
		.i_sibling_cmp(sib), .o_broadcast_cmp(bcast), .i_pin_in(pins), .o_pin_out(pout), .o_pin_oe_n(poe_n),
		.o_timer_output_signal(tflag), .o_input_edge_event(eflag), .o_capture_value(capv), .o_irq(irq));
	pin_world far (.i_clk_sys(clk), .i_level(lvl), .i_sib_req(sib_req), .i_pin_out(pout), .i_pin_oe_n(poe_n),
		.o_pins(pins), .o_sib(sib));

	task automatic chk(input string n, input logic [15:0] s, e);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{a, 16'h0, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(output logic b);
		@(posedge clk);
		cmp <= 1'b1;
		sib_req <= 1'b1;
		@(posedge clk);
		cmp <= 1'b0;
		sib_req <= 1'b0;
		#1 b = bcast;
		@(posedge clk);
		#1;
	endtask
	task automatic t_force();
		logic [15:0] d;
		// Own pin selected, idle level opposite to the driven one
		lvl[0] <= 1'b1;
		sel <= 2'h0;
		wr(ADDR_CTRL, 16'h000d);
		chk("flag", tflag, 1);
		chk("oe_n", poe_n, 0);
		rd(ADDR_CTRL, d);
		chk("ctrl", d & 16'h01ff, 16'h0109);
		wr(ADDR_CTRL, 16'h0003);
		chk("pin", pout, 0);
		chk("shared", pins[0], 0);
		rd(ADDR_CTRL, d);
		chk("own pin", d[8], 0);
		rd(4'hf, d);
		chk("unmapped", d, 0);
		@(posedge clk);
		sel <= 2'h2;
	endtask
	task automatic t_sib();
		logic b;
		wr(ADDR_CTRL, 16'h0030);
		chk("oe_n off", poe_n, 1);
		pulse(b);
		chk("bcast", b, 1);
		chk("sib flag", tflag, 0);
		wr(ADDR_CTRL, 16'h0008);
		pulse(b);
		chk("no bcast", b, 0);
		chk("no sib", tflag, 0);
	endtask
	task automatic t_capture_value_register();
		logic [15:0] c, x;
		logic hit, cur, prv;
		x = 0;
		prv = 1'b0;
		wr(ADDR_IRQ_ENABLE, 16'h1);
		for (int m = 0; m < 9; m++)
		begin
			c = (m == 8) ? 16'h00c0 : {6'h0, m[2], 1'b0, m[1:0], 6'h0};
			for (int e = 0; e < 2; e++)
			begin
				// Mode write, then input step on the edge that takes it
				@(posedge clk);
				req <= '{ADDR_CTRL, c, 1'b1, 1'b0};
				@(posedge clk);
				req.wr <= 1'b0;
				cmode <= (m == 8) ? 3'h0 : 3'h1;
				cv <= 16'(m * 16 + e + 1);
				lvl[2] <= !e[0];
				repeat (4) @(posedge clk);
				#1;
				// Adjusted level before and after the step decides the edge
				cur = !e[0] ^ c[9];
				hit = (cur && !prv) ? c[6] : ((!cur && prv) ? c[7] : 1'b0);
				prv = cur;
				if (hit)
					x = cv;
				chk("capture", capv, x);
				chk("edge", eflag, hit && m != 8);
			end
		end
	endtask
	task automatic t_irq();
		logic [15:0] d;
		chk("irq", irq, 1);
		rd(ADDR_IRQ_STATUS, d);
		chk("status", d[0], 1);
		wr(ADDR_IRQ_ENABLE, 16'h0);
		#8 chk("masked", irq, 0);
		wr(ADDR_IRQ_CLEAR, 16'h3);
		rd(ADDR_IRQ_STATUS, d);
		chk("cleared", d, 0);
	endtask
	task automatic test_done();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// 125 MHz clock
	initial
	begin
		forever #4 clk = ~clk;
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_force();
		t_sib();
		t_capture_value_register();
		t_irq();
		test_done();
	end
	// Watchdog, far beyond the roughly 150 cycles needed
	initial
	begin
		#20000;
		bad_count++;
		test_done();
	end
endmodule // tb
